// >>> cmb_msg_buffer.sv
// One CAN message buffer object with an APB register port and an engine port.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer (
   input  wire logic        pclk,           // Clock, 40 MHz.
   input  wire logic        presetn,        // Asynchronous reset, active low.
   input  wire logic        psel,           // APB select.
   input  wire logic        penable,        // APB enable.
   input  wire logic        pwrite,         // APB write.
   input  wire logic [7:0]  paddr,          // APB byte address.
   input  wire logic [31:0] pwdata,         // APB write data.
   input  wire logic [3:0]  pstrb,          // APB byte strobes.
   output logic      [31:0] prdata,         // APB read data.
   output logic             pready,         // APB ready.
   output logic             pslverr,        // APB error.
   input  wire logic        eng_rx_store,   // Engine stores a received frame.
   input  wire logic [28:0] eng_rx_id,      // Received identifier, right aligned.
   input  wire logic        eng_rx_ide,     // Received extension bit.
   input  wire logic        eng_rx_rtr,     // Received remote bit.
   input  wire logic        eng_rx_srr,     // Received substitute bit.
   input  wire logic [3:0]  eng_rx_dlc,     // Received length code.
   input  wire logic [63:0] eng_rx_data,    // Received payload, byte one on top.
   input  wire logic [15:0] eng_rx_buffer_time_stamp,    // Time stamp of the reception.
   input  wire logic        eng_state_wr,   // Engine updates the state code.
   input  wire logic [3:0]  eng_state,      // New buffer state code.
   output logic      [28:0] tx_id,          // Identifier to send.
   output logic             tx_ide,         // Extension bit to send.
   output logic             tx_rtr,         // Remote bit to send.
   output logic             tx_srr,         // Substitute bit to send.
   output logic      [3:0]  tx_byte_count,  // Payload bytes to send, 0 to 8.
   output logic      [63:0] tx_data,        // Payload, unused bytes zero.
   output logic      [3:0]  tx_prio,        // Transmit priority code.
   output logic      [3:0]  buf_state       // Buffer state code.
);

   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------
   // Returns {hit, slot}; only word-aligned even indices are mapped.
   function automatic logic [3:0] word_sel(input logic [7:0] addr);
      logic [3:0] idx;
      idx = addr[5:2];
      if (addr[1:0] == 2'b00 && addr[7:6] == 2'b00 && !idx[0]) begin
         word_sel = {1'b1, idx[3:1]};
      end else begin
         word_sel = 4'h0;
      end
   endfunction

   cmb_pkg::cmb_state_t st_ff;
   cmb_pkg::cmb_state_t nxt_st;

   logic [3:0]  rd_sel;
   logic [3:0]  wr_sel;
   logic        busy;
   logic        u_ide;
   logic        u_rtr;
   logic        u_srr;
   logic [28:0] u_id;
   logic [15:0] p_idh;
   logic [15:0] p_idl;
   logic [3:0]  tx_cnt;
   logic [63:0] tx_mask;
   logic [63:0] rx_mask;
   logic [63:0] rx_kept;
   logic [63:0] tx_raw;

   assign rd_sel = word_sel(paddr);
   assign wr_sel = rd_sel;
   assign busy   = st_ff.word[cmb_pkg::W_STATUS][cmb_pkg::STAT_BUSY_BIT];

   // ----------------------------------------------------------------
   // Format helpers.
   // ----------------------------------------------------------------
   cmb_id_codec u_codec (
      .idh_in (st_ff.word[cmb_pkg::W_IDHI]),
      .idl_in (st_ff.word[cmb_pkg::W_IDLO]),
      .u_ide  (u_ide),
      .u_rtr  (u_rtr),
      .u_srr  (u_srr),
      .u_id   (u_id),
      .p_id   (eng_rx_id),
      .p_ide  (eng_rx_ide),
      .p_rtr  (eng_rx_rtr),
      .p_srr  (eng_rx_srr),
      .p_idh  (p_idh),
      .p_idl  (p_idl)
   );

   cmb_len_clip u_tx_len (
      .dlc       (st_ff.word[cmb_pkg::W_STATUS][cmb_pkg::STAT_DLC_LSB +: 4]),
      .remote    (u_rtr),
      .count     (tx_cnt),
      .byte_mask (tx_mask)
   );

   cmb_len_clip u_rx_len (
      .dlc       (eng_rx_dlc),
      .remote    (eng_rx_rtr),
      .count     (),
      .byte_mask (rx_mask)
   );

   assign rx_kept = eng_rx_data & rx_mask;

   assign tx_raw = {st_ff.word[cmb_pkg::W_PAY0], st_ff.word[cmb_pkg::W_PAY1],
                    st_ff.word[cmb_pkg::W_PAY2], st_ff.word[cmb_pkg::W_PAY3]};

   // ----------------------------------------------------------------
   // Next state.
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // Read data and error are settled in the setup cycle so that the
      // access phase can finish without wait states.
      if (psel && !penable) begin
         if (rd_sel[3]) begin
            if (rd_sel[2:0] == cmb_pkg::W_STATUS) begin
               nxt_st.prdata = {16'h0000, st_ff.word[rd_sel[2:0]] & cmb_pkg::STAT_READ_MASK};
            end else begin
               nxt_st.prdata = {16'h0000, st_ff.word[rd_sel[2:0]]};
            end
            nxt_st.pslverr = pwrite && busy && (rd_sel[2:0] != cmb_pkg::W_STATUS);
         end else begin
            nxt_st.prdata  = cmb_pkg::PRDATA_IDLE;
            nxt_st.pslverr = 1'b1;
         end
      end

      // Software writes; a busy buffer accepts only the low status byte.
      if (psel && penable && pwrite && wr_sel[3]) begin
         if (wr_sel[2:0] == cmb_pkg::W_STATUS) begin
            if (pstrb[0]) begin
               nxt_st.word[cmb_pkg::W_STATUS][7:0] = pwdata[7:0];
            end
            if (pstrb[1] && !busy) begin
               nxt_st.word[cmb_pkg::W_STATUS][15:12] = pwdata[15:12];
            end
         end else if (!busy) begin
            if (pstrb[0]) begin
               nxt_st.word[wr_sel[2:0]][7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               nxt_st.word[wr_sel[2:0]][15:8] = pwdata[15:8];
            end
         end
      end

      // Engine updates come last so that they win over a software write
      // in the same cycle.
      if (eng_rx_store) begin
         nxt_st.word[cmb_pkg::W_IDHI]  = p_idh;
         nxt_st.word[cmb_pkg::W_IDLO]  = p_idl;
         nxt_st.word[cmb_pkg::W_PAY0]  = rx_kept[63:48];
         nxt_st.word[cmb_pkg::W_PAY1]  = rx_kept[47:32];
         nxt_st.word[cmb_pkg::W_PAY2]  = rx_kept[31:16];
         nxt_st.word[cmb_pkg::W_PAY3]  = rx_kept[15:0];
         nxt_st.word[cmb_pkg::W_STAMP] = eng_rx_buffer_time_stamp;
         nxt_st.word[cmb_pkg::W_STATUS][cmb_pkg::STAT_DLC_LSB +: 4] = eng_rx_dlc;
      end
      if (eng_state_wr) begin
         nxt_st.word[cmb_pkg::W_STATUS][cmb_pkg::STAT_STATE_LSB +: 4] = eng_state;
      end

      // Transmit view of the current contents, one cycle behind storage.
      // frame format out
      nxt_st.tx_ide   = u_ide;
      nxt_st.tx_id    = u_id;
      nxt_st.tx_rtr   = u_rtr;
      nxt_st.tx_srr   = u_srr;
      nxt_st.tx_count = tx_cnt;
      nxt_st.tx_data  = tx_raw & tx_mask;
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign pready        = 1'b1;
   assign prdata        = st_ff.prdata;
   assign pslverr       = st_ff.pslverr;
   assign tx_id         = st_ff.tx_id;
   assign tx_ide        = st_ff.tx_ide;
   assign tx_rtr        = st_ff.tx_rtr;
   assign tx_srr        = st_ff.tx_srr;
   assign tx_byte_count = st_ff.tx_count;
   assign tx_data       = st_ff.tx_data;
   assign tx_prio       = st_ff.word[cmb_pkg::W_STATUS][cmb_pkg::STAT_PRIO_LSB +: 4];
   assign buf_state     = st_ff.word[cmb_pkg::W_STATUS][cmb_pkg::STAT_STATE_LSB +: 4];

endmodule
`default_nettype wire

// >>> cmb_pkg.sv
// Constants and types shared by the CAN message buffer block.
`default_nettype none
package cmb_pkg;

   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_STATUS = 4'h0;
   localparam logic [3:0] IDX_STAMP  = 4'h2;
   localparam logic [3:0] IDX_PAY3   = 4'h4;
   localparam logic [3:0] IDX_PAY2   = 4'h6;
   localparam logic [3:0] IDX_PAY1   = 4'h8;
   localparam logic [3:0] IDX_PAY0   = 4'ha;
   localparam logic [3:0] IDX_IDLO   = 4'hc;
   localparam logic [3:0] IDX_IDHI   = 4'he;

   // Storage slots, one per register (index divided by two).
   localparam logic [2:0] W_STATUS = 3'h0;
   localparam logic [2:0] W_STAMP  = 3'h1;
   localparam logic [2:0] W_PAY3   = 3'h2;
   localparam logic [2:0] W_PAY2   = 3'h3;
   localparam logic [2:0] W_PAY1   = 3'h4;
   localparam logic [2:0] W_PAY0   = 3'h5;
   localparam logic [2:0] W_IDLO   = 3'h6;
   localparam logic [2:0] W_IDHI   = 3'h7;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int STAT_DLC_LSB  = 12;
   localparam int STAT_PRIO_LSB  = 4;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int IDH_ID_LSB     = 5;
   localparam int IDH_RTR_BIT    = 4;
   localparam int IDH_SRR_BIT    = 4;
   localparam int IDH_IDE_BIT    = 3;
   localparam int IDH_EXTM_LSB   = 0;
   localparam int IDL_EXTL_LSB   = 1;
   localparam int IDL_RTR_BIT    = 0;

   // ----------------------------------------------------------------
   // Values.
   // ----------------------------------------------------------------
   localparam logic [15:0] WORD_RESET      = 16'h0000;
   localparam logic [15:0] STAT_READ_MASK  = 16'hf0ff;
   localparam logic [3:0]  MAX_BYTES       = 4'h8;
   localparam logic [15:0] INVALID_WORD    = 16'h0000;
   localparam logic [31:0] PRDATA_IDLE     = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Block state.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0][15:0] word;
      logic [31:0]      prdata;
      logic             pslverr;
      logic [28:0]      tx_id;
      logic             tx_ide;
      logic             tx_rtr;
      logic             tx_srr;
      logic [3:0]       tx_count;
      logic [63:0]      tx_data;
   } cmb_state_t;

endpackage
`default_nettype wire

// >>> cmb_len_clip.sv
// Length code clipping and payload byte mask.
`timescale 1ns/1ps
`default_nettype none
module cmb_len_clip (
   input  wire logic [3:0]  dlc,        // Stored or received length code.
   input  wire logic        remote,     // Frame is a remote frame.
   output logic      [3:0]  count,      // Payload byte count, 0 to 8.
   output logic      [63:0] byte_mask   // Ones over the valid payload bytes.
);

   assign count = (dlc > cmb_pkg::MAX_BYTES) ? cmb_pkg::MAX_BYTES : dlc;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_byte
         assign byte_mask[63-8*i -: 8] = (!remote && (count > 4'(i))) ? 8'hff : 8'h00;
      end
   endgenerate

endmodule
`default_nettype wire

// >>> cmb_id_codec.sv
// Identifier word packing and unpacking for both frame formats.
`timescale 1ns/1ps
`default_nettype none
module cmb_id_codec (
   input  wire logic [15:0] idh_in,     // Stored upper identifier word.
   input  wire logic [15:0] idl_in,     // Stored lower identifier word.
   output logic             u_ide,      // Unpacked extension bit.
   output logic             u_rtr,      // Unpacked remote bit.
   output logic             u_srr,      // Unpacked substitute bit.
   output logic      [28:0] u_id,       // Unpacked identifier, right aligned.
   input  wire logic [28:0] p_id,       // Identifier to pack.
   input  wire logic        p_ide,      // Extension bit to pack.
   input  wire logic        p_rtr,      // Remote bit to pack.
   input  wire logic        p_srr,      // Substitute bit to pack.
   output logic      [15:0] p_idh,      // Packed upper identifier word.
   output logic      [15:0] p_idl       // Packed lower identifier word.
);

   assign u_ide = idh_in[cmb_pkg::IDH_IDE_BIT];

   always_comb begin
      if (u_ide) begin
         u_id  = {idh_in[15:cmb_pkg::IDH_ID_LSB], idh_in[cmb_pkg::IDH_EXTM_LSB +: 3],
                  idl_in[15:cmb_pkg::IDL_EXTL_LSB]};
         u_rtr = idl_in[cmb_pkg::IDL_RTR_BIT];
         u_srr = idh_in[cmb_pkg::IDH_SRR_BIT];
      end else begin
         u_id  = {18'h00000, idh_in[15:cmb_pkg::IDH_ID_LSB]};
         u_rtr = idh_in[cmb_pkg::IDH_RTR_BIT];
         u_srr = 1'b0;
      end
   end

   always_comb begin
      if (p_ide) begin
         p_idh = {p_id[28:18], p_srr, 1'b1, p_id[17:15]};
         p_idl = {p_id[14:0], p_rtr};
      end else begin
         // standard packing, low bits zero
         // The extension bit sits at bit 3, so only three bits are left over.
         p_idh = {p_id[10:0], p_rtr, 1'b0, 3'h0};
         p_idl = cmb_pkg::INVALID_WORD;
      end
   end

endmodule
`default_nettype wire

// >>> cmb_dummy_placeholder_removed.sv
// Intentionally empty file holding no design code.

// >>> cmb_msg_buffer_chk.sv
// Port assertions for the CAN message buffer.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer_chk (
   input wire logic        pclk,          // Clock.
   input wire logic        presetn,       // Reset.
   input wire logic        eng_rx_store,  // Store strobe.
   input wire logic [28:0] eng_rx_id,     // Rx id.
   input wire logic        eng_rx_ide,    // Rx format.
   input wire logic        eng_rx_srr,    // Rx substitute.
   input wire logic [3:0]  eng_rx_dlc,    // Rx length.
   input wire logic [28:0] tx_id,         // Tx id.
   input wire logic        tx_ide,        // Tx format.
   input wire logic        tx_rtr,        // Tx remote.
   input wire logic        tx_srr,        // Tx substitute.
   input wire logic [3:0]  tx_byte_count, // Tx count.
   input wire logic [63:0] tx_data        // Tx payload.
);
   // Ones over the bytes that the present count lets through.
   logic [63:0] keep;
   always_comb keep = ~(64'hffff_ffff_ffff_ffff >> {tx_byte_count, 3'h0});

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   cnt_clip_a: assert property (tx_byte_count <= 4'h8)
      else $error("count above eight");
   len_mask_a: assert property ((tx_data & ~keep) == 64'h0)
      else $error("byte beyond count");
   rtr_quiet_a: assert property (tx_rtr |-> tx_data == 64'h0)
      else $error("remote payload");
   std_clean_a: assert property (!tx_ide |-> !tx_srr && tx_id[28:11] == 18'h0)
      else $error("standard leaks bits");
   rx_fmt_a: assert property (eng_rx_store |-> ##2 tx_ide == $past(eng_rx_ide, 2))
      else $error("format lost");
   rx_len_a: assert property (eng_rx_store |-> ##2 tx_byte_count ==
      ($past(eng_rx_dlc, 2) > 4'h8 ? 4'h8 : $past(eng_rx_dlc, 2)))
      else $error("count wrong");
   std_id_a: assert property (eng_rx_store && !eng_rx_ide |-> ##2
      tx_id == {18'h0, $past(eng_rx_id[10:0], 2)})
      else $error("standard id wrong");
   ext_id_a: assert property (eng_rx_store && eng_rx_ide |-> ##2
      tx_id == $past(eng_rx_id, 2) && tx_srr == $past(eng_rx_srr, 2))
      else $error("extended id wrong");
endmodule
bind cmb_msg_buffer cmb_msg_buffer_chk i_chk (
   .pclk, .presetn, .eng_rx_store, .eng_rx_id, .eng_rx_ide, .eng_rx_srr,
   .eng_rx_dlc, .tx_id, .tx_ide, .tx_rtr, .tx_srr, .tx_byte_count, .tx_data
);
`default_nettype wire

// >>> cmb_can_engine_model.sv
// Behavioural model of the CAN protocol engine beside the buffer.
`timescale 1ns/1ps
`default_nettype none
module cmb_can_engine_model (
   input  wire logic        pclk,         // Clock.
   output logic             eng_rx_store, // Store strobe.
   output logic      [28:0] eng_rx_id,    // Identifier.
   output logic             eng_rx_ide,   // Format bit.
   output logic             eng_rx_rtr,   // Remote bit.
   output logic             eng_rx_srr,   // Substitute bit.
   output logic      [3:0]  eng_rx_dlc,   // Length code.
   output logic      [63:0] eng_rx_data,  // Payload.
   output logic      [15:0] eng_rx_buffer_time_stamp,  // Time stamp.
   output logic             eng_state_wr, // State strobe.
   output logic      [3:0]  eng_state     // State code.
);
   initial begin
      {eng_rx_store, eng_state_wr, eng_state} = 6'h00;
      {eng_rx_id, eng_rx_ide, eng_rx_rtr, eng_rx_srr} = 32'h0;
      {eng_rx_dlc, eng_rx_data, eng_rx_buffer_time_stamp} = 84'h0;
   end

   task automatic rx(input logic [28:0] id, input logic [2:0] irs,
                     input logic [3:0] dlc, input logic [63:0] d,
                     input logic [15:0] ts, input int gap);
      repeat (gap) @(posedge pclk);
      eng_rx_store <= 1'b1;
      {eng_rx_id, eng_rx_ide, eng_rx_rtr, eng_rx_srr, eng_rx_dlc, eng_rx_data,
       eng_rx_buffer_time_stamp} <= {id, irs, dlc, d, ts};
      @(posedge pclk);
      eng_rx_store <= 1'b0;
      // A stale frame must never look valid, so released fields flip.
      {eng_rx_id, eng_rx_ide, eng_rx_rtr, eng_rx_srr, eng_rx_dlc, eng_rx_data,
       eng_rx_buffer_time_stamp} <= ~{id, irs, dlc, d, ts};
   endtask

   // One state update, taken at the next rising edge.
   task automatic set_state(input logic [3:0] s);
      eng_state_wr <= 1'b1;
      eng_state <= s;
      @(posedge pclk);
      eng_state_wr <= 1'b0;
      eng_state <= ~s;
   endtask
endmodule
`default_nettype wire

// >>> cmb_msg_buffer_test.sv
// Self-checking testbench for the CAN message buffer.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        eng_rx_store, eng_rx_ide, eng_rx_rtr, eng_rx_srr, eng_state_wr;
   logic        tx_ide, tx_rtr, tx_srr;
   logic [3:0]  pstrb, eng_rx_dlc, tx_byte_count, tx_prio, buf_state, eng_state;
   logic [7:0]  paddr;
   logic [15:0] eng_rx_buffer_time_stamp, rd;
   logic [28:0] eng_rx_id, tx_id, id;
   logic [31:0] pwdata, prdata;
   logic [63:0] eng_rx_data, tx_data, pay;
   int          failures, check_count, n;

   cmb_msg_buffer i_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .eng_rx_store, .eng_rx_id, .eng_rx_ide, .eng_rx_rtr,
      .eng_rx_srr, .eng_rx_dlc, .eng_rx_data, .eng_rx_buffer_time_stamp, .eng_state_wr, .eng_state,
      .tx_id, .tx_ide, .tx_rtr, .tx_srr, .tx_byte_count, .tx_data, .tx_prio, .buf_state
   );
   cmb_can_engine_model i_eng (
      .pclk, .eng_rx_store, .eng_rx_id, .eng_rx_ide, .eng_rx_rtr, .eng_rx_srr,
      .eng_rx_dlc, .eng_rx_data, .eng_rx_buffer_time_stamp, .eng_state_wr, .eng_state
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, then one idle cycle so requests never collide.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         failures++;
         end_sim();
      end
      rd = prdata[15:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      xfer(1'b1, {2'h0, i, 2'h0}, d, 4'h3);
   endtask

   task automatic rdc(input logic [3:0] i, input logic [15:0] e);
      xfer(1'b0, {2'h0, i, 2'h0}, 16'h0000, 4'h0);
      chk(rd, e);
   endtask

   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      failures = 0;
      check_count = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 1; i < 8; i++) begin
         wr(4'(2 * i), 16'ha5c3 ^ 16'(i));
         rdc(4'(2 * i), 16'ha5c3 ^ 16'(i));
      end
      xfer(1'b0, 8'h04, 16'h0000, 4'h0);
      chk({er, rd}, 17'h10000);
      $display("test registers done");
      pay = 64'h0102_0304_0506_0708;
      // Remote and extension bits clear, the three spare bits set.
      wr(cmb_pkg::IDX_IDHI, {11'h5a3, 5'h07});
      wr(cmb_pkg::IDX_IDLO, 16'hffff);
      for (int i = 0; i < 4; i++) begin
         wr(4'(4'ha - 2 * i), pay[63 - 16 * i -: 16]);
      end
      wr(cmb_pkg::IDX_STATUS, 16'h8000);
      repeat (2) @(posedge pclk);
      chk(tx_id, 29'h5a3);
      chk({tx_ide, tx_rtr, tx_srr}, 3'h0);
      chk(tx_data, pay);
      $display("test standard view done");
      for (int d = 0; d < 16; d++) begin
         wr(cmb_pkg::IDX_STATUS, {4'(d), 12'h000});
         repeat (2) @(posedge pclk);
         chk(tx_byte_count, (d > 8) ? 8 : d);
         chk(tx_data, pay & ~(64'hffff_ffff_ffff_ffff >> (8 * ((d > 8) ? 8 : d))));
      end
      $display("test length codes done");
      id = 29'h1abc_def5;
      for (int r = 0; r < 2; r++) begin
         wr(cmb_pkg::IDX_IDHI, {id[28:18], 2'h3, id[17:15]});
         wr(cmb_pkg::IDX_IDLO, {id[14:0], 1'(r)});
         repeat (2) @(posedge pclk);
         chk(tx_id, id);
         chk({tx_ide, tx_srr, tx_rtr}, {2'h3, 1'(r)});
         chk(tx_data, r ? 64'h0 : pay);
      end
      $display("test extended view done");
      i_eng.rx(29'h0000_0123, 3'h1, 4'h3, 64'haabb_ccdd_eeff_1122, 16'h7e57, 0);
      rdc(cmb_pkg::IDX_PAY0, 16'haabb);
      rdc(cmb_pkg::IDX_PAY1, 16'hcc00);
      rdc(cmb_pkg::IDX_PAY3, 16'h0000);
      rdc(cmb_pkg::IDX_IDHI, {11'h123, 5'h00});
      rdc(cmb_pkg::IDX_STATUS, 16'h3000);
      id = 29'h0f0f_0f0f;
      i_eng.rx(id, 3'h6, 4'hc, 64'hffff_ffff_ffff_ffff, 16'h1234, 3);
      for (int i = 0; i < 4; i++) begin
         rdc(4'(4 + 2 * i), 16'h0000);
      end
      rdc(cmb_pkg::IDX_IDHI, {id[28:18], 2'h1, id[17:15]});
      rdc(cmb_pkg::IDX_IDLO, {id[14:0], 1'b1});
      rdc(cmb_pkg::IDX_STATUS, 16'hc000);
      $display("test engine frames done");
      wr(cmb_pkg::IDX_STATUS, 16'h5f75);
      rdc(cmb_pkg::IDX_STATUS, 16'h5075);
      chk({tx_byte_count, tx_prio, buf_state}, 12'h575);
      // The busy buffer must refuse this write and keep its identifier.
      xfer(1'b1, {2'h0, cmb_pkg::IDX_IDLO, 2'h0}, 16'h0000, 4'h3);
      chk(er, 1'b1);
      rdc(cmb_pkg::IDX_IDLO, {id[14:0], 1'b1});
      wr(cmb_pkg::IDX_STATUS, 16'h9f70);
      chk(er, 1'b0);
      rdc(cmb_pkg::IDX_STATUS, 16'h5070);
      i_eng.set_state(4'h3);
      rdc(cmb_pkg::IDX_STATUS, 16'h5073);
      chk(buf_state, 4'h3);
      $display("test status word done");
      presetn <= 1'b0;
      @(posedge pclk);
      chk({pready, pslverr, prdata, tx_prio, buf_state}, {1'b1, 41'h0});
      chk({tx_ide, tx_rtr, tx_srr, tx_byte_count, tx_id}, 36'h0);
      chk(tx_data, 64'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(cmb_pkg::IDX_IDHI, 16'h0000);
      $display("test reset done");
      end_sim();
   end
endmodule
`default_nettype wire
